// >>> hdl/awgsq_top.sv
// segment sequencer of one waveform channel
// source store outside: data appears one cycle after its address
module awgsq_top
  import awgsq_pkg::*;
#(
  parameter int NSEG = MAX_SEGS,
  parameter int IDX_W = $clog2(MAX_SEGS)
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic RUN,
  input wire logic [2:0] RUN_MODE,
  input wire logic [1:0] TRIG_SEL,
  input wire logic [1:0] UP_METHOD,
  input wire logic [1:0] DOWN_METHOD,
  input wire logic [REP_W-1:0] BURST_COUNT,
  input wire logic [IDX_W:0] SEG_COUNT,
  input wire logic [TMR_W-1:0] TIMER_PERIOD,
  input wire logic TRIG_BTN,
  input wire logic TRIG_EXT,
  input wire logic [PCT_W-1:0] AMP_PCT,
  input wire logic [IDX_W-1:0] MARK_SEG,
  input wire logic [LEN_W-1:0] MARK_POINT,
  input wire logic SEG_WR,
  input wire logic [IDX_W-1:0] SEG_WR_IDX,
  input wire logic [ADDR_W-1:0] SEG_WR_BASE,
  input wire logic [LEN_W-1:0] SEG_WR_SRC_LEN,
  input wire logic [LEN_W-1:0] SEG_WR_LEN,
  input wire logic [REP_W-1:0] SEG_WR_REPEAT,
  input wire logic [AMP_W-1:0] SEG_WR_AMP,
  input wire logic SEG_WR_JUMP_EN,
  input wire logic [IDX_W-1:0] SEG_WR_JUMP_TO,
  input wire logic [1:0] SEG_WR_JUMP_TRIG,
  input wire logic signed [SMP_W-1:0] WAVE_DATA_A,
  input wire logic signed [SMP_W-1:0] WAVE_DATA_B,
  output logic [ADDR_W-1:0] WAVE_ADDR_A,
  output logic [ADDR_W-1:0] WAVE_ADDR_B,
  output logic WAVE_RD,
  output logic signed [SMP_W-1:0] SAMPLE,
  output logic SAMPLE_VALID,
  output logic MARKER,
  output logic BUSY,
  output logic [IDX_W-1:0] SEG_NOW,
  output logic SEG_WR_REJECT,
  output logic SEQ_DONE
);
  if (NSEG < 1 || NSEG > MAX_SEGS || NSEG > (1 << IDX_W)) begin : g_chk
    $error("awgsq_top: NSEG out of range");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [LEN_W-1:0] src_len;
    logic [LEN_W-1:0] len;
    logic [REP_W-1:0] repeats;
    logic [AMP_W-1:0] amp;
    logic jump_en;
    logic [IDX_W-1:0] jump_to;
    logic [1:0] jump_trig;
  } awgsq_seg_s;

  typedef struct packed {
    awgsq_seg_s [NSEG-1:0] tab;
    awgsq_state_e st;
    logic run_q;
    logic [IDX_W-1:0] seg;
    logic [LEN_W-1:0] pt;
    logic [REP_W-1:0] rep;
    logic [REP_W-1:0] pass;
    logic jump_pend;
    logic wr_rej;
    logic done;
    logic busy;
    // stage 0: addresses out
    logic v0;
    logic [ADDR_W-1:0] addr_a;
    logic [ADDR_W-1:0] addr_b;
    logic [FRAC_W-1:0] frac0;
    logic zero0;
    logic [AMP_W-1:0] amp0;
    logic mark0;
    // stage 1: data returns
    logic v1;
    logic [FRAC_W-1:0] frac1;
    logic zero1;
    logic [AMP_W-1:0] amp1;
    logic mark1;
    // stage 2: sample out
    logic v2;
    logic signed [SMP_W-1:0] smp;
    logic mark2;
  } awgsq_top_s;

  logic [1:0] rst_sync;
  logic rst_n;
  awgsq_top_s r;
  awgsq_top_s n;
  logic [2:0] trig_vec;
  awgsq_seg_s cur;
  logic [LEN_W-1:0] idx_a;
  logic [LEN_W-1:0] idx_b;
  logic [FRAC_W-1:0] frac;
  logic zero;

  // legal length check for a new segment
  function automatic logic len_ok(input logic [LEN_W-1:0] len);
    len_ok = (len >= LEN_MIN) &&
             ((len >= LEN_FREE) || (len[LEN_GRAN_BITS-1:0] == '0));
  endfunction

  // blend, apply segment gain, channel percentage, then saturate
  function automatic logic signed [SMP_W-1:0] shape(
    input logic signed [SMP_W-1:0] a,
    input logic signed [SMP_W-1:0] b,
    input logic [FRAC_W-1:0] f,
    input logic [AMP_W-1:0] amp,
    input logic [PCT_W-1:0] pct
  );
    logic signed [SMP_W:0] diff;
    logic signed [SMP_W+FRAC_W+1:0] prod;
    logic signed [SMP_W+1:0] mix;
    logic signed [SMP_W+AMP_W+2:0] g;
    logic signed [SMP_W+AMP_W+PCT_W+3:0] p;
    diff = (SMP_W+1)'(b) - (SMP_W+1)'(a);
    prod = (SMP_W+FRAC_W+2)'(diff) * $signed({1'b0, f});
    mix = (SMP_W+2)'(a) + (SMP_W+2)'(prod >>> FRAC_W);
    g = (SMP_W+AMP_W+3)'(mix) * $signed({1'b0, amp});
    g = g >>> AMP_UNITY_SHIFT;
    p = (SMP_W+AMP_W+PCT_W+4)'(g) * $signed({1'b0, pct});
    p = p / $signed({1'b0, PCT_FULL});
    if (p > (SMP_W+AMP_W+PCT_W+4)'(32767)) begin
      shape = 16'sh7fff;
    end else if (p < -(SMP_W+AMP_W+PCT_W+4)'(32768)) begin
      shape = -16'sh8000;
    end else begin
      shape = p[SMP_W-1:0];
    end
  endfunction

  // reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  awgsq_trig u_trig (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .timer_en(r.st != ST_IDLE),
    .timer_period(TIMER_PERIOD),
    .btn(TRIG_BTN),
    .ext_pin(TRIG_EXT),
    .pulse(trig_vec)
  );

  assign cur = r.tab[r.seg];

  awgsq_resamp u_resamp (
    .pt(r.pt),
    .src_len(cur.src_len),
    .seg_len(cur.len),
    .up_method(UP_METHOD),
    .dn_method(DOWN_METHOD),
    .idx_a(idx_a),
    .idx_b(idx_b),
    .frac(frac),
    .zero(zero)
  );

  always_comb begin
    logic trig_now;
    logic jtrig;
    logic last;
    logic jump;
    logic [IDX_W-1:0] nseg;
    logic [3:0] tv4;
    // select code 3 means no trigger; padding keeps the index in range
    tv4 = {1'b0, trig_vec};
    n = r;
    trig_now = tv4[TRIG_SEL];
    jtrig = tv4[cur.jump_trig];
    last = ({1'b0, r.seg} + 1'b1 >= SEG_COUNT);
    jump = 1'b0;
    nseg = '0;
    n.run_q = RUN;
    n.wr_rej = 1'b0;
    n.done = 1'b0;
    n.v0 = 1'b0;

    // editing only while stopped; bad entries leave the table alone
    if (SEG_WR) begin
      if (r.st != ST_IDLE) begin
        n.wr_rej = 1'b1;
      end else if (!len_ok(SEG_WR_LEN) || SEG_WR_REPEAT < REP_MIN ||
                   SEG_WR_SRC_LEN == '0 ||
                   {1'b0, SEG_WR_IDX} >= (IDX_W+1)'(NSEG)) begin
        n.wr_rej = 1'b1;
      end else begin
        n.tab[SEG_WR_IDX] = '{SEG_WR_BASE, SEG_WR_SRC_LEN, SEG_WR_LEN,
                              SEG_WR_REPEAT, SEG_WR_AMP, SEG_WR_JUMP_EN,
                              SEG_WR_JUMP_TO, SEG_WR_JUMP_TRIG};
      end
    end

    case (r.st)
      ST_IDLE: begin
        if (RUN && !r.run_q && SEG_COUNT != '0) begin
          n.seg = '0;
          n.pt = '0;
          n.rep = r.tab[0].repeats;
          n.pass = (BURST_COUNT == '0) ? REP_MIN : BURST_COUNT;
          n.jump_pend = 1'b0;
          if (RUN_MODE == RUN_CONT) begin
            n.st = ST_PLAY;
          end else begin
            n.st = ST_ARM;
          end
        end
      end
      ST_ARM, ST_STEP: begin
        if (trig_now) begin
          n.st = ST_PLAY;
        end
      end
      ST_PLAY: begin
        n.v0 = 1'b1;
        n.addr_a = cur.base + ADDR_W'(idx_a);
        n.addr_b = cur.base + ADDR_W'(idx_b);
        n.frac0 = frac;
        n.zero0 = zero;
        n.amp0 = cur.amp;
        n.mark0 = (r.seg == MARK_SEG) && (r.pt == MARK_POINT);
        // a jump trigger seen mid-segment waits for the segment end
        if (RUN_MODE == RUN_ADV && cur.jump_en && jtrig) begin
          n.jump_pend = 1'b1;
        end
        if (r.pt + 20'h00001 >= cur.len) begin
          n.pt = '0;
          if (r.rep > REP_MIN) begin
            n.rep = r.rep - 16'h0001;
          end else begin
            if (RUN_MODE == RUN_ADV && cur.jump_en &&
                (r.jump_pend || jtrig)) begin
              jump = 1'b1;
              nseg = cur.jump_to;
            end else if (last) begin
              nseg = '0;
            end else begin
              nseg = r.seg + 1'b1;
            end
            n.seg = nseg;
            n.rep = r.tab[nseg].repeats;
            n.jump_pend = 1'b0;
            if (RUN_MODE == RUN_STEP) begin
              n.st = ST_STEP;
            end else if (RUN_MODE == RUN_BURST && last && !jump) begin
              if (r.pass > REP_MIN) begin
                n.pass = r.pass - 16'h0001;
              end else begin
                n.st = ST_IDLE;
                n.done = 1'b1;
              end
            end
          end
        end else begin
          n.pt = r.pt + 20'h00001;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // dropping RUN stops at once; the pipe still drains its samples
    if (!RUN) begin
      n.st = ST_IDLE;
    end
    n.busy = (n.st != ST_IDLE);

    n.v1 = r.v0;
    n.frac1 = r.frac0;
    n.zero1 = r.zero0;
    n.amp1 = r.amp0;
    n.mark1 = r.mark0;
    n.v2 = r.v1;
    n.mark2 = r.v1 & r.mark1;
    if (!r.v1 || r.zero1) begin
      n.smp = '0;
    end else begin
      n.smp = shape(WAVE_DATA_A, WAVE_DATA_B, r.frac1, r.amp1,
                    AMP_PCT);
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign WAVE_ADDR_A = r.addr_a;
  assign WAVE_ADDR_B = r.addr_b;
  assign WAVE_RD = r.v0;
  assign SAMPLE = r.smp;
  assign SAMPLE_VALID = r.v2;
  assign MARKER = r.mark2;
  assign BUSY = r.busy;
  assign SEG_NOW = r.seg;
  assign SEG_WR_REJECT = r.wr_rej;
  assign SEQ_DONE = r.done;
endmodule // awgsq_top

// >>> shared/awgsq_pkg.sv
// constants, enumerations and widths of the segment sequencer
// assumes one sample clock; the source waveform store sits outside
package awgsq_pkg;

  localparam int MAX_SEGS = 1024;
  localparam int LEN_W = 20;
  localparam int ADDR_W = 24;
  localparam int REP_W = 16;
  localparam int SMP_W = 16;
  localparam int AMP_W = 16;
  localparam int PCT_W = 7;
  localparam int FRAC_W = 8;
  localparam int TMR_W = 32;

  localparam logic [LEN_W-1:0] LEN_MIN = 20'h00040;
  localparam logic [LEN_W-1:0] LEN_FREE = 20'h00100;
  localparam int LEN_GRAN_BITS = 4;
  localparam logic [REP_W-1:0] REP_MIN = 16'h0001;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam int AMP_UNITY_SHIFT = 15;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM = 4'h2,
    ST_PLAY = 4'h4,
    ST_STEP = 4'h8
  } awgsq_state_e;

  typedef enum logic [2:0] {
    RUN_CONT = 3'h0,
    RUN_BURST = 3'h1,
    RUN_INFIN = 3'h2,
    RUN_STEP = 3'h3,
    RUN_ADV = 3'h4
  } awgsq_run_e;

  typedef enum logic [1:0] {
    TRG_BTN = 2'h0,
    TRG_TIMER = 2'h1,
    TRG_EXT = 2'h2
  } awgsq_trg_e;

  typedef enum logic [1:0] {
    UP_INTERP = 2'h0,
    UP_ZERO = 2'h1,
    UP_HOLD = 2'h2,
    UP_DUP = 2'h3
  } awgsq_up_e;

  typedef enum logic [1:0] {
    DN_DECIM = 2'h0,
    DN_CUT_TAIL = 2'h1,
    DN_CUT_HEAD = 2'h2
  } awgsq_dn_e;

endpackage

// >>> hdl/awgsq_resamp.sv
// maps a point of a segment to source sample indices
// purely combinational; the caller registers the result
module awgsq_resamp
  import awgsq_pkg::*;
(
  input wire logic [LEN_W-1:0] pt,
  input wire logic [LEN_W-1:0] src_len,
  input wire logic [LEN_W-1:0] seg_len,
  input wire logic [1:0] up_method,
  input wire logic [1:0] dn_method,
  output logic [LEN_W-1:0] idx_a,
  output logic [LEN_W-1:0] idx_b,
  output logic [FRAC_W-1:0] frac,
  output logic zero
);
  logic [2*LEN_W-1:0] num;
  logic [2*LEN_W-1:0] quo;
  logic [2*LEN_W-1:0] rem;
  logic [2*LEN_W+FRAC_W-1:0] fr;
  logic [LEN_W-1:0] last;

  // the divides are wide; a serial divider would trade area for latency
  always_comb begin
    num = 40'(pt) * 40'(src_len);
    quo = num / 40'(seg_len);
    rem = num % 40'(seg_len);
    fr = {rem, 8'h00} / 48'(seg_len);
    last = src_len - 20'h00001;
    idx_a = pt;
    idx_b = pt;
    frac = '0;
    zero = 1'b0;
    if (src_len < seg_len) begin
      case (up_method)
        UP_INTERP: begin
          idx_a = quo[LEN_W-1:0];
          idx_b = (quo[LEN_W-1:0] < last) ? quo[LEN_W-1:0] + 20'h00001 : last;
          frac = fr[FRAC_W-1:0];
        end
        UP_ZERO: zero = (pt >= src_len);
        UP_HOLD: begin
          idx_a = (pt > last) ? last : pt;
          idx_b = idx_a;
        end
        default: begin
          idx_a = pt % src_len;
          idx_b = idx_a;
        end
      endcase
    end else if (src_len > seg_len) begin
      case (dn_method)
        DN_DECIM: begin
          idx_a = quo[LEN_W-1:0];
          idx_b = idx_a;
        end
        DN_CUT_HEAD: begin
          idx_a = pt + (src_len - seg_len);
          idx_b = idx_a;
        end
        default: begin
          idx_a = pt;
          idx_b = pt;
        end
      endcase
    end
  end
endmodule // awgsq_resamp

// >>> hdl/awgsq_trig.sv
// produces pulses for the three trigger sources; the button pulse lasts as long as btn
// ext pin is asynchronous; button comes from logic on the same clock
module awgsq_trig
  import awgsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic timer_en,
  input wire logic [TMR_W-1:0] timer_period,
  input wire logic btn,
  input wire logic ext_pin,
  output logic [2:0] pulse
);
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [TMR_W-1:0] tcnt;
    logic [2:0] pulse;
  } awgsq_trig_s;

  awgsq_trig_s r;
  awgsq_trig_s n;

  always_comb begin
    n = r;
    n.ext_s1 = ext_pin;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    n.pulse = '0;
    n.pulse[TRG_BTN] = btn;
    n.pulse[TRG_EXT] = r.ext_s2 & ~r.ext_s3;
    // timer restarts when disabled so the first tick is one period late
    if (!timer_en) begin
      n.tcnt = '0;
    end else if (r.tcnt + 32'h1 >= timer_period) begin
      n.tcnt = '0;
      n.pulse[TRG_TIMER] = 1'b1;
    end else begin
      n.tcnt = r.tcnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pulse = r.pulse;
endmodule // awgsq_trig

// >>> tb/awgsq_chk.sv
// port checker of the segment sequencer
// bound into awgsq_top; sees its ports only, one clock domain
module awgsq_chk
  import awgsq_pkg::*;
#(
  parameter int NSEG = MAX_SEGS,
  parameter int IDX_W = $clog2(MAX_SEGS)
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic RUN,
  input wire logic [2:0] RUN_MODE,
  input wire logic [IDX_W:0] SEG_COUNT,
  input wire logic SEG_WR,
  input wire logic [IDX_W-1:0] SEG_WR_IDX,
  input wire logic [LEN_W-1:0] SEG_WR_SRC_LEN,
  input wire logic [LEN_W-1:0] SEG_WR_LEN,
  input wire logic [REP_W-1:0] SEG_WR_REPEAT,
  input wire logic WAVE_RD,
  input wire logic SAMPLE_VALID,
  input wire logic MARKER,
  input wire logic BUSY,
  input wire logic [IDX_W-1:0] SEG_NOW,
  input wire logic SEG_WR_REJECT,
  input wire logic SEQ_DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);
  // a write within every limit must be taken
  wire logic wr_ok = !BUSY && SEG_WR_LEN >= LEN_MIN && SEG_WR_REPEAT != '0
    && (SEG_WR_LEN >= LEN_FREE || SEG_WR_LEN[3:0] == 4'h0)
    && SEG_WR_SRC_LEN != '0 && SEG_WR_IDX < NSEG;
  len_short_a: assert property (
    SEG_WR && SEG_WR_LEN < LEN_MIN |=> SEG_WR_REJECT)
    else $error("short segment length not refused");
  len_gran_a: assert property (
    SEG_WR && SEG_WR_LEN < LEN_FREE && SEG_WR_LEN[3:0] != 4'h0
    |=> SEG_WR_REJECT) else $error("odd short length not refused");
  rep_zero_a: assert property (
    SEG_WR && SEG_WR_REPEAT == '0 |=> SEG_WR_REJECT)
    else $error("zero repeat not refused");
  edit_lock_a: assert property (
    SEG_WR && BUSY |=> SEG_WR_REJECT) else $error("edit while busy taken");
  wr_take_a: assert property (
    SEG_WR && wr_ok |=> !SEG_WR_REJECT) else $error("legal write refused");
  cont_start_a: assert property (
    $rose(RUN) && !BUSY && SEG_COUNT != '0 && RUN_MODE == RUN_CONT
    ##1 RUN [*3] |-> BUSY && WAVE_RD ##1 SAMPLE_VALID)
    else $error("continuous start timing wrong");
  mark_align_a: assert property (
    MARKER |-> SAMPLE_VALID ##1 !MARKER)
    else $error("marker not a lone sample pulse");
  done_stop_a: assert property (
    SEQ_DONE |=> !SEQ_DONE && !BUSY) else $error("burst did not stop");
  idle_quiet_a: assert property (
    !BUSY [*4] |-> !SAMPLE_VALID && !WAVE_RD)
    else $error("output while idle");
  seg_range_a: assert property (
    BUSY && SEG_COUNT != '0 |-> SEG_NOW < SEG_COUNT)
    else $error("segment index past list end");
  cover property ($rose(BUSY));
  cover property (SEQ_DONE);
  cover property (MARKER);
endmodule // awgsq_chk

bind awgsq_top awgsq_chk #(.NSEG(NSEG), .IDX_W(IDX_W)) chk_u (
  .CORE_CLK, .NRST, .RUN, .RUN_MODE, .SEG_COUNT, .SEG_WR, .SEG_WR_IDX,
  .SEG_WR_SRC_LEN, .SEG_WR_LEN, .SEG_WR_REPEAT, .WAVE_RD, .SAMPLE_VALID,
  .MARKER, .BUSY, .SEG_NOW, .SEG_WR_REJECT, .SEQ_DONE);

// >>> tb/awgsq_wave_mdl.sv
// source waveform store model on the far side of the sequencer
// answers one cycle after the address; value is four times the low 12
// address bits, so a half-step blend shows up in the output
module awgsq_wave_mdl
  import awgsq_pkg::*;
(
  input wire logic clk,
  input wire logic rd,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [ADDR_W-1:0] addr_b,
  output logic signed [SMP_W-1:0] data_a,
  output logic signed [SMP_W-1:0] data_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial data_a = '0;
  initial data_b = '0;
  // unread cycles show the inverse so stale data never passes
  always @(posedge clk) begin
    data_a <= rd ? SMP_W'({addr_a[11:0], 2'b00}) : ~data_a;
    data_b <= rd ? SMP_W'({addr_b[11:0], 2'b00}) : ~data_b;
  end
endmodule // awgsq_wave_mdl

// >>> tb/testbench.sv
// self-checking bench of the segment sequencer
// wave store is awgsq_wave_mdl; inputs move on falling edges
module testbench
  import awgsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NS = 6;
  localparam int IW = 3;
  logic CORE_CLK, NRST, RUN, TRIG_BTN, TRIG_EXT, SEG_WR, SEG_WR_JUMP_EN;
  logic [2:0] RUN_MODE;
  logic [1:0] TRIG_SEL, UP_METHOD, DOWN_METHOD, SEG_WR_JUMP_TRIG;
  logic [REP_W-1:0] BURST_COUNT, SEG_WR_REPEAT;
  logic [IW:0] SEG_COUNT;
  logic [TMR_W-1:0] TIMER_PERIOD;
  logic [PCT_W-1:0] AMP_PCT;
  logic [IW-1:0] MARK_SEG, SEG_WR_IDX, SEG_NOW, SEG_WR_JUMP_TO;
  logic [LEN_W-1:0] MARK_POINT, SEG_WR_SRC_LEN, SEG_WR_LEN;
  logic [ADDR_W-1:0] SEG_WR_BASE, WAVE_ADDR_A, WAVE_ADDR_B;
  logic signed [SMP_W-1:0] WAVE_DATA_A, WAVE_DATA_B, SAMPLE;
  logic WAVE_RD, SAMPLE_VALID, MARKER, BUSY, SEG_WR_REJECT, SEQ_DONE;
  int mismatches = 0;
  int checked = 0;

  awgsq_top #(.NSEG(NS), .IDX_W(IW)) dut_u (
    .CORE_CLK, .NRST, .RUN, .RUN_MODE, .TRIG_SEL, .UP_METHOD, .DOWN_METHOD,
    .BURST_COUNT, .SEG_COUNT, .TIMER_PERIOD, .TRIG_BTN, .TRIG_EXT, .AMP_PCT,
    .MARK_SEG, .MARK_POINT, .SEG_WR, .SEG_WR_IDX, .SEG_WR_BASE,
    .SEG_WR_SRC_LEN, .SEG_WR_LEN, .SEG_WR_REPEAT, .SEG_WR_AMP(16'h8000),
    .SEG_WR_JUMP_EN, .SEG_WR_JUMP_TO, .SEG_WR_JUMP_TRIG,
    .WAVE_DATA_A, .WAVE_DATA_B, .WAVE_ADDR_A, .WAVE_ADDR_B, .WAVE_RD,
    .SAMPLE, .SAMPLE_VALID, .MARKER, .BUSY, .SEG_NOW, .SEG_WR_REJECT,
    .SEQ_DONE);
  awgsq_wave_mdl store_u (.clk(CORE_CLK), .rd(WAVE_RD), .addr_a(WAVE_ADDR_A),
    .addr_b(WAVE_ADDR_B), .data_a(WAVE_DATA_A), .data_b(WAVE_DATA_B));

  always #2 CORE_CLK = ~CORE_CLK;

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask

  // expected store value per point, four per address step;
  // kinds 0-6 resample, 7 two segments; blend clamps at the last point
  function automatic int ex(input int kd, input int k);
    case (kd)
      0: return k < 63 ? 1024 + 2 * k : 1148;
      1: return k < 32 ? 1024 + 4 * k : 0;
      2: return 1024 + 4 * (k < 32 ? k : 31);
      3: return 1024 + 4 * (k % 32);
      4: return 1024 + 8 * k;
      5: return 1024 + 4 * k;
      6: return 1280 + 4 * k;
      default: return k % 192 < 128 ? 1024 + 4 * (k % 64) :
        1536 + 4 * (k % 192);
    endcase
  endfunction

  task automatic wr(input int i, b, s, l, r, output logic rj);
    @(negedge CORE_CLK);
    SEG_WR = 1'b1;
    SEG_WR_IDX = IW'(i);
    SEG_WR_BASE = ADDR_W'(b);
    SEG_WR_SRC_LEN = LEN_W'(s);
    SEG_WR_LEN = LEN_W'(l);
    SEG_WR_REPEAT = REP_W'(r);
    @(negedge CORE_CLK);
    SEG_WR = 1'b0;
    rj = SEG_WR_REJECT;
  endtask

  task automatic load2();
    logic rj;
    wr(0, 256, 64, 64, 2, rj);
    wr(1, 512, 64, 64, 1, rj);
    SEG_COUNT = 4'h2;
  endtask

  task automatic halt();
    RUN = 1'b0;
    repeat (10) @(negedge CORE_CLK);
  endtask

  task automatic fire(input int ts);
    TRIG_BTN = ts == 0;
    TRIG_EXT = ts == 2;
    @(negedge CORE_CLK);
    TRIG_BTN = 1'b0;
    TRIG_EXT = 1'b0;
  endtask

  // counts samples until the stream has been quiet for 100 cycles
  task automatic count_out(output int n);
    int q;
    n = 0;
    q = 0;
    while (q < 100) begin
      @(negedge CORE_CLK);
      if (SAMPLE_VALID === 1'b1) begin
        n++;
        q = 0;
      end else begin
        q++;
      end
    end
  endtask

  task automatic play(input int kd, input int n);
    int t;
    RUN = 1'b1;
    t = 0;
    while (SAMPLE_VALID !== 1'b1 && t < 20) begin
      @(negedge CORE_CLK);
      t++;
    end
    for (int k = 0; k < n; k++) begin
      chk(32'(SAMPLE_VALID), 32'h1);
      chk(32'(SAMPLE), 32'(ex(kd, k) * AMP_PCT / 100));
      chk(32'(MARKER), 32'(kd == 7 && k % 192 == 133));
      @(negedge CORE_CLK);
    end
  endtask

  task automatic t_refuse();
    logic rj;
    int rows [7][5] = '{'{0, 64, 63, 1, 1}, '{0, 64, 72, 1, 1},
      '{0, 64, 64, 0, 1}, '{0, 0, 64, 1, 1}, '{6, 64, 64, 1, 1},
      '{0, 64, 80, 1, 0}, '{0, 300, 257, 1, 0}};
    for (int j = 0; j < 7; j++) begin
      wr(rows[j][0], 256, rows[j][1], rows[j][2], rows[j][3], rj);
      chk(32'(rj), 32'(rows[j][4]));
    end
  endtask

  task automatic t_cont();
    logic rj;
    load2();
    AMP_PCT = 7'h32;
    RUN_MODE = 3'h0;
    play(7, 260);
    wr(0, 256, 64, 64, 2, rj);
    chk(32'(rj), 32'h1);
    halt();
  endtask

  task automatic t_resamp();
    logic rj;
    SEG_COUNT = 4'h1;
    AMP_PCT = 7'h64;
    for (int kd = 0; kd < 7; kd++) begin
      UP_METHOD = 2'(kd);
      DOWN_METHOD = 2'(kd - 4);
      wr(0, 256, kd < 4 ? 32 : 128, 64, 1, rj);
      play(kd, 64);
      halt();
    end
  endtask

  task automatic t_trig();
    int n;
    load2();
    RUN_MODE = 3'h1;
    for (int ts = 0; ts < 3; ts++) begin
      TRIG_SEL = 2'(ts);
      BURST_COUNT = REP_W'(ts + 1);
      RUN = 1'b1;
      // the timer fires by itself, so only button and pin wait first
      if (ts != 1) begin
        count_out(n);
        chk(32'(n), 32'h0);
        fire(ts);
      end
      count_out(n);
      chk(32'(n), 32'((ts + 1) * 192));
      chk(32'(BUSY), 32'h0);
      halt();
    end
  endtask

  task automatic t_step();
    int n;
    load2();
    RUN_MODE = 3'h3;
    TRIG_SEL = 2'h2;
    RUN = 1'b1;
    for (int s = 0; s < 3; s++) begin
      fire(2);
      count_out(n);
      chk(32'(n), s == 1 ? 32'h40 : 32'h80);
    end
    halt();
  endtask

  task automatic t_inf();
    int n;
    RUN_MODE = 3'h2;
    TRIG_SEL = 2'h0;
    RUN = 1'b1;
    count_out(n);
    chk(32'(n), 32'h0);
    fire(0);
    play(7, 400);
    chk(32'(BUSY), 32'h1);
    halt();
  endtask

  task automatic t_adv();
    logic rj;
    SEG_WR_JUMP_EN = 1'b1;
    SEG_WR_JUMP_TO = 3'h2;
    wr(0, 256, 64, 64, 1, rj);
    SEG_WR_JUMP_EN = 1'b0;
    wr(1, 512, 64, 64, 1, rj);
    wr(2, 768, 64, 64, 1, rj);
    SEG_COUNT = 4'h3;
    RUN_MODE = 3'h4;
    TRIG_SEL = 2'h0;
    RUN = 1'b1;
    fire(0);
    // second pulse lands inside segment 0, so its end jumps to 2
    repeat (20) @(negedge CORE_CLK);
    fire(0);
    repeat (60) @(negedge CORE_CLK);
    chk(32'(SEG_NOW), 32'h2);
    repeat (128) @(negedge CORE_CLK);
    chk(32'(SEG_NOW), 32'h1);
    halt();
  endtask

  initial begin
    CORE_CLK = 1'b0;
    NRST = 1'b0;
    RUN = 1'b0;
    TRIG_BTN = 1'b0;
    TRIG_EXT = 1'b0;
    SEG_WR = 1'b0;
    RUN_MODE = 3'h0;
    TRIG_SEL = 2'h0;
    UP_METHOD = 2'h0;
    DOWN_METHOD = 2'h0;
    BURST_COUNT = 16'h0001;
    SEG_COUNT = 4'h0;
    TIMER_PERIOD = 32'h0000003c;
    AMP_PCT = 7'h64;
    MARK_SEG = 3'h1;
    MARK_POINT = 20'h00005;
    SEG_WR_IDX = 3'h0;
    SEG_WR_BASE = 24'h000000;
    SEG_WR_SRC_LEN = 20'h00000;
    SEG_WR_LEN = 20'h00000;
    SEG_WR_REPEAT = 16'h0000;
    SEG_WR_JUMP_EN = 1'b0;
    SEG_WR_JUMP_TO = 3'h0;
    SEG_WR_JUMP_TRIG = 2'h0;
    repeat (10) @(negedge CORE_CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CORE_CLK);
    t_refuse();
    t_cont();
    t_resamp();
    t_trig();
    t_step();
    t_inf();
    t_adv();
    tally_and_finish();
  end

  // watchdog: several times the expected length of the run
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    mismatches++;
    tally_and_finish();
  end
endmodule // testbench
